// File: src/ipr_ctrl.sv
// Interrupt priority controller top with register slave and boot logic.
//
// The address map and register access over AXI4-Lite were decided locally.

module ipr_ctrl
  import ipr_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic [NUM_SRC-1:0] I_SRC_EVENT,
  input wire logic [3:0] I_CPU_IPL,
  output logic O_IRQ,
  output logic [ID_W-1:0] O_IRQ_VECTOR,
  output logic [LVL_W-1:0] O_IRQ_LEVEL,
  input wire logic I_WDT_EXPIRED,
  input wire logic I_UNINIT_PTR,
  input wire logic I_ILLEGAL_EXEC,
  input wire logic I_EXEC_FLUSHED,
  input wire logic I_SUPPLY_DIP,
  input wire logic [TRAP_W-1:0] I_TRAP,
  output logic O_CORE_RESET,
  output logic O_FETCH_REQ,
  output logic [PC_W-1:0] O_FETCH_ADDR,
  input wire logic I_FETCH_VALID,
  input wire logic [PC_W-1:0] I_FETCH_DATA,
  output logic O_START_VALID,
  output logic [PC_W-1:0] O_START_ADDR
);

  typedef struct packed {
    logic [NUM_SRC-1:0] flag;
    logic [NUM_SRC-1:0] enable;
    ipr_prio_arr_t prio;
    ipr_cause_t cause;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] dip_sync;
    logic irq;
    logic [ID_W-1:0] vector;
    logic [LVL_W-1:0] lvl;
    ipr_boot_t boot;
    logic [2:0] hold_cnt;
    logic [PC_W-1:0] fetch_addr;
    logic [PC_W-1:0] start_addr;
  } ipr_state_t;

  ipr_state_t state_reg;
  ipr_state_t state_next;
  ipr_win_t win;
  ipr_cause_t cause_now;
  logic [NUM_SRC-1:0] pending;

  typedef enum logic [2:0] {
    REG_FLAG = 3'b000,
    REG_ENABLE = 3'b001,
    REG_PRIO = 3'b010,
    REG_CAUSE = 3'b011,
    REG_STATUS = 3'b100,
    REG_NONE = 3'b101
  } ipr_region_t;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // One decoder serves reads and writes so both always agree on the map.
  function automatic ipr_region_t region(input logic [5:0] idx);
    if (idx < IDX_ENABLE) begin
      region = REG_FLAG;
    end else if (idx < IDX_PRIO) begin
      region = REG_ENABLE;
    end else if (idx < IDX_CAUSE) begin
      region = REG_PRIO;
    end else if (idx == IDX_CAUSE) begin
      region = REG_CAUSE;
    end else if (idx == IDX_STATUS) begin
      region = REG_STATUS;
    end else begin
      region = REG_NONE;
    end
  endfunction

  function automatic int prio_src(input logic [5:0] idx, input int k);
    prio_src = (int'(idx) - int'(IDX_PRIO)) * 4 + k;
  endfunction

  function automatic int lane_lsb(input logic [5:0] idx);
    lane_lsb = 16 * int'(idx[1:0]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = region(addr[7:2]) != REG_NONE;
  endfunction

  function automatic logic [31:0] read_word(input ipr_state_t st,
                                            input ipr_win_t w,
                                            input logic [5:0] idx);
    logic [63:0] fp;
    logic [63:0] ep;
    int b;
    fp = {10'h000, st.flag};
    ep = {10'h000, st.enable};
    read_word = '0;
    b = 0;
    case (region(idx))
      REG_FLAG: begin
        read_word[15:0] = fp[lane_lsb(idx) +: 16];
      end
      REG_ENABLE: begin
        read_word[15:0] = ep[lane_lsb(idx) +: 16];
      end
      REG_PRIO: begin
        for (int k = 0; k < 4; k++) begin
          b = prio_src(idx, k);
          if (b < NUM_SRC) begin
            read_word[4*k +: 3] = st.prio[b];
          end
          read_word[4*k+3] = 1'b0;
        end
      end
      REG_CAUSE: begin
        read_word[CAUSE_W-1:0] = st.cause;
      end
      REG_STATUS: begin
        read_word[13:0] = {st.boot, w.valid, st.vector, st.lvl, st.irq};
      end
      default: begin
        read_word = '0;
      end
    endcase
  endfunction

  assign pending = state_reg.flag & state_reg.enable & IMPL_MASK;

  ipr_arb u_arb (
    .i_pending(pending),
    .i_prio(state_reg.prio),
    .o_win(win)
  );

  ipr_rst u_rst (
    .i_wdt_expired(I_WDT_EXPIRED),
    .i_uninit_ptr(I_UNINIT_PTR),
    .i_illegal_exec(I_ILLEGAL_EXEC),
    .i_exec_flushed(I_EXEC_FLUSHED),
    .i_supply_dip(state_reg.dip_sync[1]),
    .i_trap(I_TRAP),
    .o_cause(cause_now)
  );

  always_comb begin
    logic [63:0] fl_pad;
    logic [63:0] en_pad;
    logic [5:0] widx;
    logic [CAUSE_W-1:0] cause_clr;
    int b;
    int lane;
    state_next = state_reg;
    fl_pad = {10'h000, state_reg.flag};
    en_pad = {10'h000, state_reg.enable};
    widx = state_reg.aw_addr[7:2];
    cause_clr = '0;
    b = 0;
    lane = lane_lsb(widx);

    // The supply-dip pin is asynchronous to I_CLK.
    state_next.dip_sync = {state_reg.dip_sync[0], I_SUPPLY_DIP};

    if (I_AWVALID && O_AWREADY) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      state_next.w_got = 1'b1;
      state_next.w_data = I_WDATA;
      state_next.w_strb = I_WSTRB;
    end
    if (state_reg.bvalid && I_BREADY) begin
      state_next.bvalid = 1'b0;
    end

    if (state_reg.aw_got && state_reg.w_got) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = mapped(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (region(widx))
        REG_FLAG: begin
          fl_pad[lane +: 16] = merge16(fl_pad[lane +: 16], state_reg.w_data,
                                       state_reg.w_strb);
        end
        REG_ENABLE: begin
          en_pad[lane +: 16] = merge16(en_pad[lane +: 16], state_reg.w_data,
                                       state_reg.w_strb);
        end
        REG_PRIO: begin
          for (int k = 0; k < 4; k++) begin
            b = prio_src(widx, k);
            if (b < NUM_SRC && state_reg.w_strb[k/2]) begin
              state_next.prio[b] = state_reg.w_data[4*k +: 3];
            end
          end
        end
        REG_CAUSE: begin
          if (state_reg.w_strb[0]) begin
            cause_clr = state_reg.w_data[CAUSE_W-1:0];
          end
        end
        default: begin
          cause_clr = '0;
        end
      endcase
    end

    if (state_reg.rvalid && I_RREADY) begin
      state_next.rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word(state_reg, win, I_ARADDR[7:2]);
      state_next.rresp = mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end

    // A source event in the clearing cycle still sets its flag.
    state_next.flag = (fl_pad[NUM_SRC-1:0] | I_SRC_EVENT) & IMPL_MASK;
    state_next.enable = en_pad[NUM_SRC-1:0];
    state_next.cause = (state_reg.cause & ~cause_clr) | cause_now;

    state_next.irq = win.valid && (state_reg.boot == BOOT_RUN) &&
                     ({1'b0, win.lvl} > I_CPU_IPL);
    state_next.vector = vec_of(win.id);
    state_next.lvl = win.lvl;

    case (state_reg.boot)
      BOOT_HOLD: begin
        state_next.fetch_addr = RESET_PC;
        if (state_reg.hold_cnt == RST_HOLD_LAST) begin
          state_next.boot = BOOT_FETCH_JUMP;
        end else begin
          state_next.hold_cnt = 3'(state_reg.hold_cnt + 3'h1);
        end
      end
      BOOT_FETCH_JUMP: begin
        if (I_FETCH_VALID) begin
          state_next.fetch_addr = RESET_PC + PC_STEP;
          state_next.boot = BOOT_FETCH_TGT;
        end
      end
      BOOT_FETCH_TGT: begin
        if (I_FETCH_VALID) begin
          state_next.start_addr = I_FETCH_DATA;
          state_next.boot = BOOT_RUN;
        end
      end
      BOOT_RUN: begin
        state_next.boot = BOOT_RUN;
      end
      default: begin
        state_next.boot = BOOT_HOLD;
      end
    endcase

    // Any reset condition restarts the core and the interrupt state.
    if (cause_now != '0) begin
      state_next.boot = BOOT_HOLD;
      state_next.hold_cnt = '0;
      state_next.fetch_addr = RESET_PC;
      state_next.start_addr = RESET_PC;
      state_next.flag = '0;
      state_next.enable = '0;
      state_next.prio = '0;
      state_next.irq = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign O_AWREADY = !state_reg.aw_got && !state_reg.bvalid;
  assign O_WREADY = !state_reg.w_got && !state_reg.bvalid;
  assign O_BVALID = state_reg.bvalid;
  assign O_BRESP = state_reg.bresp;
  assign O_ARREADY = !state_reg.rvalid;
  assign O_RVALID = state_reg.rvalid;
  assign O_RDATA = state_reg.rdata;
  assign O_RRESP = state_reg.rresp;
  assign O_IRQ = state_reg.irq;
  assign O_IRQ_VECTOR = state_reg.vector;
  assign O_IRQ_LEVEL = state_reg.lvl;
  assign O_CORE_RESET = state_reg.boot == BOOT_HOLD;
  assign O_FETCH_REQ = state_reg.boot == BOOT_FETCH_JUMP ||
                       state_reg.boot == BOOT_FETCH_TGT;
  assign O_FETCH_ADDR = state_reg.fetch_addr;
  assign O_START_VALID = state_reg.boot == BOOT_RUN;
  assign O_START_ADDR = state_reg.start_addr;

endmodule // ipr_ctrl

// File: src/ipr_pkg.sv
// Shared constants and types for the interrupt priority controller.
package ipr_pkg;

  localparam int NUM_SRC = 54;
  localparam int ID_W = 6;
  localparam int LVL_W = 3;
  localparam int TRAP_W = 4;
  localparam int ADDR_W = 8;
  localparam int PC_W = 24;

  // Interrupt number to vector number distance.
  localparam logic [ID_W-1:0] VEC_OFFSET = 6'h08;

  // Sources that exist; all other numbers are reserved.
  localparam logic [NUM_SRC-1:0] IMPL_MASK = 54'h980_0BFF_FFFF;

  // Motor-control source numbers.
  localparam logic [ID_W-1:0] SRC_EXT_ZERO = 6'h00;
  localparam logic [ID_W-1:0] SRC_PWM_PERIOD = 6'h27;
  localparam logic [ID_W-1:0] SRC_QUAD_ENC = 6'h28;
  localparam logic [ID_W-1:0] SRC_PWM_FAULT_A = 6'h2B;

  // Register byte offsets: flag and enable span four words each, priority fourteen, cause and status one each.
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PRIO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h5C;
  localparam logic [5:0] IDX_FLAG = OFS_FLAG[7:2];
  localparam logic [5:0] IDX_ENABLE = OFS_ENABLE[7:2];
  localparam logic [5:0] IDX_PRIO = OFS_PRIO[7:2];
  localparam logic [5:0] IDX_CAUSE = OFS_CAUSE[7:2];
  localparam logic [5:0] IDX_STATUS = OFS_STATUS[7:2];

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Boot: program counter forced here, words two addresses apart.
  localparam logic [PC_W-1:0] RESET_PC = 24'h00_0000;
  localparam logic [PC_W-1:0] PC_STEP = 24'h00_0002;

  // Core reset pulse width.
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_HOLD_NS = 100;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam logic [2:0] RST_HOLD_LAST = 3'(RST_HOLD_CYC - 1);

  typedef logic [NUM_SRC-1:0][LVL_W-1:0] ipr_prio_arr_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [LVL_W-1:0] lvl;
  } ipr_win_t;

  typedef struct packed {
    logic trap_lockout;
    logic supply_dip;
    logic illegal_op;
    logic uninit_ptr;
    logic watchdog;
  } ipr_cause_t;

  localparam int CAUSE_W = $bits(ipr_cause_t);

  typedef enum logic [2:0] {
    BOOT_HOLD = 3'b000,
    BOOT_FETCH_JUMP = 3'b001,
    BOOT_FETCH_TGT = 3'b010,
    BOOT_RUN = 3'b011
  } ipr_boot_t;

  function automatic logic [ID_W-1:0] vec_of(input logic [ID_W-1:0] id);
    vec_of = ID_W'(id + VEC_OFFSET);
  endfunction

endpackage

// File: src/ipr_arb.sv
// Priority arbiter picking the winning pending source.
module ipr_arb
  import ipr_pkg::*;
(
  input wire logic [NUM_SRC-1:0] i_pending,
  input wire ipr_prio_arr_t i_prio,
  output ipr_win_t o_win
);

  // Ascending scan with a strict compare: level decides first and on a
  // tie the lower number found earlier keeps the win.
  always_comb begin
    o_win = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i_pending[i] && IMPL_MASK[i] && i_prio[i] != '0) begin
        if (!o_win.valid || i_prio[i] > o_win.lvl) begin
          o_win.valid = 1'b1;
          o_win.id = ID_W'(i);
          o_win.lvl = i_prio[i];
        end
      end
    end
  end

endmodule // ipr_arb

// File: src/ipr_rst.sv
// Collector of the conditions that force a device reset.
module ipr_rst
  import ipr_pkg::*;
(
  input wire logic i_wdt_expired,
  input wire logic i_uninit_ptr,
  input wire logic i_illegal_exec,
  input wire logic i_exec_flushed,
  input wire logic i_supply_dip,
  input wire logic [TRAP_W-1:0] i_trap,
  output ipr_cause_t o_cause
);

  function automatic logic several(input logic [TRAP_W-1:0] v);
    int cnt;
    cnt = 0;
    for (int i = 0; i < TRAP_W; i++) begin
      cnt = cnt + int'(v[i]);
    end
    several = cnt > 1;
  endfunction

  always_comb begin
    o_cause.watchdog = i_wdt_expired;
    o_cause.uninit_ptr = i_uninit_ptr;
    o_cause.illegal_op = i_illegal_exec && !i_exec_flushed;
    o_cause.supply_dip = i_supply_dip;
    o_cause.trap_lockout = several(i_trap);
  end

endmodule // ipr_rst

// File: testbench/ipr_ctrl_asserts.sv
// Port-level assertions for the interrupt priority controller.
module ipr_ctrl_asserts
  import ipr_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic [3:0] I_CPU_IPL,
  input wire logic O_IRQ,
  input wire logic [ID_W-1:0] O_IRQ_VECTOR,
  input wire logic [LVL_W-1:0] O_IRQ_LEVEL,
  input wire logic I_WDT_EXPIRED,
  input wire logic I_UNINIT_PTR,
  input wire logic I_ILLEGAL_EXEC,
  input wire logic I_EXEC_FLUSHED,
  input wire logic I_SUPPLY_DIP,
  input wire logic [TRAP_W-1:0] I_TRAP,
  input wire logic O_CORE_RESET,
  input wire logic O_FETCH_REQ,
  input wire logic [PC_W-1:0] O_FETCH_ADDR,
  input wire logic I_FETCH_VALID,
  input wire logic [PC_W-1:0] I_FETCH_DATA,
  input wire logic O_START_VALID,
  input wire logic [PC_W-1:0] O_START_ADDR
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  AST_IRQ_ABOVE_IPL: assert property (
    O_IRQ |-> O_IRQ_LEVEL != 3'h0 && {1'b0, O_IRQ_LEVEL} > $past(I_CPU_IPL))
    else $error("irq not above ipl");
  AST_IRQ_IMPL: assert property (
    O_IRQ |-> IMPL_MASK[O_IRQ_VECTOR - VEC_OFFSET]) else $error("bad vector");
  AST_HOLD_QUIET: assert property (
    O_CORE_RESET |-> !O_FETCH_REQ && !O_IRQ && !O_START_VALID)
    else $error("activity in reset");
  AST_WDT: assert property (
    I_WDT_EXPIRED |=> O_CORE_RESET) else $error("no watchdog reset");
  AST_UNINIT: assert property (
    I_UNINIT_PTR |=> O_CORE_RESET) else $error("no pointer reset");
  AST_ILLEGAL: assert property (
    I_ILLEGAL_EXEC && !I_EXEC_FLUSHED |=> O_CORE_RESET)
    else $error("no illegal reset");
  AST_DIP: assert property (
    $rose(I_SUPPLY_DIP) |-> ##[1:4] O_CORE_RESET) else $error("no dip reset");
  AST_LOCKOUT: assert property (
    $countones(I_TRAP) > 1 |=> O_CORE_RESET) else $error("no lockout");
  AST_START: assert property (
    O_FETCH_REQ && I_FETCH_VALID && O_FETCH_ADDR == PC_STEP
    |=> O_START_VALID && O_START_ADDR == $past(I_FETCH_DATA))
    else $error("bad start address");
  AST_FIRST_FETCH: assert property (
    $rose(O_FETCH_REQ) |-> O_FETCH_ADDR == RESET_PC)
    else $error("first fetch not at zero");
endmodule // ipr_ctrl_asserts

// File: testbench/ipr_core_model.sv
// Processor core stand-in answering the two boot fetches.
module ipr_core_model
  import ipr_pkg::*;
#(
  // Jump opcode value is arbitrary.
  parameter logic [PC_W-1:0] JUMP_WORD = 24'h04_0000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fetch_req,
  input wire logic [PC_W-1:0] i_fetch_addr,
  input wire logic [3:0] i_lag,
  input wire logic [PC_W-1:0] i_start,
  output logic o_fetch_valid,
  output logic [PC_W-1:0] o_fetch_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wait_reg <= 4'h0;
      o_fetch_valid <= 1'b0;
      o_fetch_data <= 24'h5A_A5A5;
    end else if (!i_fetch_req || o_fetch_valid) begin
      // Released data bus is scrambled so stale words are never reused.
      wait_reg <= 4'h0;
      o_fetch_valid <= 1'b0;
      o_fetch_data <= ~o_fetch_data;
    end else if (wait_reg >= i_lag) begin
      o_fetch_valid <= 1'b1;
      // A fetch from anywhere but the two boot words returns a wrong word.
      if (i_fetch_addr == RESET_PC) begin
        o_fetch_data <= JUMP_WORD;
      end else if (i_fetch_addr == PC_W'(RESET_PC + PC_STEP)) begin
        o_fetch_data <= i_start;
      end else begin
        o_fetch_data <= ~i_start;
      end
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // ipr_core_model

// File: testbench/ipr_ctrl_test.sv
// Self-checking bench for the interrupt priority controller.
module ipr_ctrl_test
  import ipr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [PC_W-1:0] START = 24'h00_0120;
  logic I_CLK, I_RESETN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ;
  logic I_WDT_EXPIRED, I_UNINIT_PTR, I_ILLEGAL_EXEC, I_EXEC_FLUSHED;
  logic I_SUPPLY_DIP, I_FETCH_VALID, O_CORE_RESET, O_FETCH_REQ, O_START_VALID;
  logic [ADDR_W-1:0] I_AWADDR, I_ARADDR;
  logic [2:0] I_AWPROT, I_ARPROT, O_IRQ_LEVEL;
  logic [3:0] I_WSTRB, I_CPU_IPL, lag;
  logic [31:0] I_WDATA, O_RDATA;
  logic [1:0] O_BRESP, O_RRESP;
  logic [NUM_SRC-1:0] I_SRC_EVENT;
  logic [ID_W-1:0] O_IRQ_VECTOR;
  logic [TRAP_W-1:0] I_TRAP;
  logic [PC_W-1:0] O_FETCH_ADDR, I_FETCH_DATA, O_START_ADDR;
  int errors, samples_checked;

  ipr_ctrl dut (.*);
  ipr_core_model core (.i_clk(I_CLK), .i_rst_n(I_RESETN),
    .i_fetch_req(O_FETCH_REQ), .i_fetch_addr(O_FETCH_ADDR), .i_lag(lag),
    .i_start(START), .o_fetch_valid(I_FETCH_VALID),
    .o_fetch_data(I_FETCH_DATA));

  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s: expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic guard(input int n, input string nm);
    if (n >= 60) begin
      $display("Error %s: expected answer seen timeout", nm);
      errors++;
      finish_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r = RESP_OKAY,
                        input logic [3:0] s = 4'hF);
    int n;
    logic aw, w;
    @(posedge I_CLK);
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    I_AWVALID <= 1'b1;
    I_AWADDR <= a;
    I_WVALID <= 1'b1;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_BREADY <= 1'b1;
    while (aw || w || !O_BVALID) begin
      @(posedge I_CLK);
      aw = aw && !O_AWREADY;
      w = w && !O_WREADY;
      I_AWVALID <= aw;
      I_WVALID <= w;
      n++;
      guard(n, "write");
    end
    I_BREADY <= 1'b0;
    check("bresp", 32'(r), 32'(O_BRESP));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r = RESP_OKAY);
    int n;
    logic ar;
    @(posedge I_CLK);
    ar = 1'b1;
    n = 0;
    I_ARVALID <= 1'b1;
    I_ARADDR <= a;
    I_RREADY <= 1'b1;
    while (ar || !O_RVALID) begin
      @(posedge I_CLK);
      ar = ar && !O_ARREADY;
      I_ARVALID <= ar;
      n++;
      guard(n, "read");
    end
    I_RREADY <= 1'b0;
    check("rresp", 32'(r), 32'(O_RRESP));
    check("rdata", d, O_RDATA);
  endtask

  task automatic irq_chk(input logic q, input logic [5:0] v,
                         input logic [2:0] l);
    repeat (3) @(posedge I_CLK);
    check("irq", 32'(q), 32'(O_IRQ));
    if (q) begin
      check("vector", 32'(v), 32'(O_IRQ_VECTOR));
      check("level", 32'(l), 32'(O_IRQ_LEVEL));
    end
  endtask

  task automatic boot(input logic [3:0] l);
    int n;
    lag <= l;
    n = 0;
    while (!O_START_VALID) begin
      @(posedge I_CLK);
      n++;
      guard(n, "boot");
    end
    check("start", 32'(START), 32'(O_START_ADDR));
  endtask

  task automatic t_regs();
    axi_wr(8'h24, 32'hFFFF_FFFF);
    axi_rd(8'h24, 32'h0000_7777);
    axi_wr(8'h24, 32'h0);
    axi_wr(8'h24, 32'hFFFF_FFFF, RESP_OKAY, 4'h2);
    axi_rd(8'h24, 32'h0000_7700);
    axi_wr(8'h24, 32'h0);
    axi_rd(8'h60, 32'h0, RESP_SLVERR);
    axi_wr(8'h60, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_arb();
    axi_wr(OFS_PRIO, 32'h1);
    axi_wr(8'h44, 32'h7000);
    axi_wr(8'h48, 32'h3003);
    axi_wr(8'h38, 32'h0700);
    @(posedge I_CLK);
    I_SRC_EVENT <= 54'h980_0400_0003;
    @(posedge I_CLK);
    I_SRC_EVENT <= '0;
    irq_chk(1'b0, 6'h00, 3'h0);
    for (int i = 0; i < 4; i++) begin
      axi_wr(8'(OFS_ENABLE + 4 * i), 32'hFFFF);
    end
    irq_chk(1'b1, 6'd47, 3'h7);
    axi_rd(8'h04, 32'h0);
    axi_wr(8'h08, 32'h0900);
    irq_chk(1'b1, 6'd48, 3'h3);
    I_CPU_IPL <= 4'h3;
    irq_chk(1'b0, 6'h00, 3'h0);
    I_CPU_IPL <= 4'h2;
    irq_chk(1'b1, 6'd48, 3'h3);
    I_CPU_IPL <= 4'h0;
    axi_wr(8'h08, 32'h0);
    irq_chk(1'b1, 6'd8, 3'h1);
    axi_wr(OFS_FLAG, 32'h2);
    irq_chk(1'b0, 6'h00, 3'h0);
    axi_rd(OFS_STATUS, 32'h0000_1880);
  endtask

  task automatic t_causes();
    logic seen;
    for (int i = 0; i < 6; i++) begin
      @(posedge I_CLK);
      I_WDT_EXPIRED <= (i == 0);
      I_UNINIT_PTR <= (i == 1);
      I_ILLEGAL_EXEC <= (i == 2 || i == 5);
      I_EXEC_FLUSHED <= (i == 5);
      I_SUPPLY_DIP <= (i == 3);
      I_TRAP <= (i == 4) ? 4'h5 : 4'h0;
      repeat (3) @(posedge I_CLK);
      {I_WDT_EXPIRED, I_UNINIT_PTR, I_ILLEGAL_EXEC} <= '0;
      {I_EXEC_FLUSHED, I_SUPPLY_DIP, I_TRAP} <= '0;
      seen = O_CORE_RESET;
      repeat (8) begin
        @(posedge I_CLK);
        seen = seen | O_CORE_RESET;
      end
      check("core_reset", 32'(i < 5), 32'(seen));
      axi_rd(OFS_CAUSE, (i < 5) ? 32'h1 << i : 32'h0);
      axi_wr(OFS_CAUSE, 32'h1F);
      boot(4'(i));
    end
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    {I_RESETN, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
    {I_WDT_EXPIRED, I_UNINIT_PTR, I_ILLEGAL_EXEC, I_EXEC_FLUSHED} = '0;
    {I_SUPPLY_DIP, I_TRAP, I_AWPROT, I_ARPROT, I_CPU_IPL, lag} = '0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_SRC_EVENT} = '0;
    I_WSTRB = 4'hF;
    repeat (8) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    @(posedge I_CLK);
    check("core_reset", 32'h1, 32'(O_CORE_RESET));
    boot(4'h3);
    t_regs();
    t_arb();
    t_causes();
    finish_test();
  end
endmodule // ipr_ctrl_test

bind ipr_ctrl ipr_ctrl_asserts u_chk (.*);
